// >>> rtl/twcsp_master.sv
// Far end: two-wire bus master driving one byte at a time
`include "twcsp_params.svh"
module twcsp_master
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   twcsp_bus_if.master bus,
   input wire logic i_fast,
   input wire logic i_cmd_valid,
   input wire logic i_cmd_start,
   input wire logic i_cmd_stop,
   input wire logic i_cmd_read,
   input wire logic i_cmd_ack,
   input wire logic [7:0] i_cmd_data,
   output logic o_cmd_ready,
   output logic o_done,
   output logic [7:0] o_rd_data,
   output logic o_ack_seen
);
   import twcsp_pkg::*;

   localparam logic [9:0] QTR_REG = 10'(`TWCSP_QTR_REG);
   localparam logic [9:0] QTR_FAST = 10'(`TWCSP_QTR_FAST);

   // ----------------------------------------
   // Synchronisers and quarter-period timer
   // ----------------------------------------
   logic sda_meta;
   logic sda_sync;
   logic scl_meta;
   logic scl_sync;
   logic [9:0] tmr;
   twcsp_mstate_t state;
   logic [3:0] bit_cnt;
   logic [8:0] tx_sh;
   logic [8:0] rx_sh;
   logic scl_oe;
   logic sda_oe;
   logic stop_after;
   logic busy;
   logic half;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
      end
      else
      begin
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
         scl_meta <= bus.scl;
         scl_sync <= scl_meta;
      end
   end

   wire tick = (tmr == 10'h000);
   wire bus_idle = scl_sync & sda_sync;
   // A fresh start needs an idle bus; chained bytes and repeated starts need a held-low clock
   wire start_ok = bus_idle & (state == TWCSP_M_IDLE);
   wire chain_ok = (state == TWCSP_M_LOW);
   assign o_cmd_ready = ~busy & (i_cmd_start ? (start_ok | chain_ok) : chain_ok);
   wire accept = i_cmd_valid & o_cmd_ready;

   // Timer reloads at each tick; fast or regular rate per i_fast
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || tick || accept)
         tmr <= i_fast ? QTR_FAST : QTR_REG;
      else
         tmr <= tmr - 10'h001;
   end

   // ----------------------------------------
   // Bit sequencer: one SCL pulse per bit plus acknowledge pulse
   // ----------------------------------------
   // Data changes only in the low phase so the slave never sees a false condition
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state <= TWCSP_M_IDLE;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         bit_cnt <= 4'h0;
         tx_sh <= 9'h000;
         rx_sh <= 9'h000;
         busy <= 1'b0;
         half <= 1'b0;
         stop_after <= 1'b0;
         o_done <= 1'b0;
         o_rd_data <= `TWCSP_RST_BYTE;
         o_ack_seen <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (accept)
         begin
            busy <= 1'b1;
            bit_cnt <= 4'h0;
            stop_after <= i_cmd_stop;
            // Read: release for eight bits, then own acknowledge bit
            tx_sh <= i_cmd_read ? {8'hff, ~i_cmd_ack} : {i_cmd_data, 1'b1};
            if (i_cmd_start)
               state <= (state == TWCSP_M_IDLE) ? TWCSP_M_START : TWCSP_M_RS_A;
         end
         else if (tick)
         begin
            case (state)
               TWCSP_M_START:
               begin
                  sda_oe <= 1'b1;
                  state <= TWCSP_M_RS_B;
               end
               TWCSP_M_RS_A:
               begin
                  sda_oe <= 1'b0;
                  scl_oe <= 1'b0;
                  state <= TWCSP_M_START;
               end
               TWCSP_M_RS_B:
               begin
                  scl_oe <= 1'b1;
                  state <= TWCSP_M_LOW;
               end
               // Two quarters low: data moves mid-low, clock rises a quarter later
               TWCSP_M_LOW:
                  if (busy)
                  begin
                     half <= ~half;
                     if (!half)
                        sda_oe <= ~tx_sh[8];
                     else
                     begin
                        scl_oe <= 1'b0;
                        state <= TWCSP_M_HIGH;
                     end
                  end
               // Two quarters high, so a full bit is four quarters
               TWCSP_M_HIGH:
               begin
                  half <= ~half;
                  if (half)
                  begin
                     scl_oe <= 1'b1;
                     rx_sh <= {rx_sh[7:0], sda_sync};
                     tx_sh <= {tx_sh[7:0], 1'b1};
                     bit_cnt <= bit_cnt + 4'h1;
                     state <= TWCSP_M_LOW;
                     if (bit_cnt == `TWCSP_BYTE_BITS)
                     begin
                        busy <= 1'b0;
                        o_done <= 1'b1;
                        o_rd_data <= rx_sh[7:0];
                        o_ack_seen <= ~sda_sync;
                        if (stop_after)
                           state <= TWCSP_M_STOP_A;
                     end
                  end
               end
               TWCSP_M_STOP_A:
               begin
                  sda_oe <= 1'b1;
                  state <= TWCSP_M_STOP_B;
               end
               TWCSP_M_STOP_B:
               begin
                  scl_oe <= 1'b0;
                  state <= TWCSP_M_STOP_C;
               end
               TWCSP_M_STOP_C:
               begin
                  sda_oe <= 1'b0;
                  state <= TWCSP_M_IDLE;
               end
               default:
                  state <= state;
            endcase
         end
      end
   end
   assign bus.m_scl_oe = scl_oe;
   assign bus.m_sda_oe = sda_oe;
endmodule : twcsp_master

// >>> rtl/twcsp_params.svh
// Constants shared by both ends of the two-wire configuration slave port
`ifndef TWCSP_PARAMS_SVH
`define TWCSP_PARAMS_SVH
// Fixed device identifier, arbitrary neutral value
`define TWCSP_DEV_ID 4'ha
// Field positions inside the address byte
`define TWCSP_ID_MSB 7
`define TWCSP_ID_LSB 4
`define TWCSP_BID_MSB 3
`define TWCSP_BID_LSB 1
`define TWCSP_RW_BIT 0
// Bits per byte and reset values
`define TWCSP_BYTE_BITS 4'h8
`define TWCSP_RST_BYTE 8'h00
// Master clock timing: regular mode 100 kHz, fast mode 400 kHz
`define TWCSP_SYS_CLK_HZ 100000000
`define TWCSP_SCL_REG_HZ 100000
`define TWCSP_SCL_FAST_HZ 400000
// Quarter SCL period in system cycles, rounded down
`define TWCSP_QTR_REG ((`TWCSP_SYS_CLK_HZ / `TWCSP_SCL_REG_HZ) / 4)
`define TWCSP_QTR_FAST ((`TWCSP_SYS_CLK_HZ / `TWCSP_SCL_FAST_HZ) / 4)
`endif

// >>> rtl/twcsp_pkg.sv
// Types shared by both ends of the two-wire configuration slave port
package twcsp_pkg;
   typedef enum logic [2:0]
   {
      TWCSP_S_IDLE = 3'b000,
      TWCSP_S_ADDR = 3'b001,
      TWCSP_S_AACK = 3'b010,
      TWCSP_S_RX = 3'b011,
      TWCSP_S_RACK = 3'b100,
      TWCSP_S_TX = 3'b101,
      TWCSP_S_TACK = 3'b110,
      TWCSP_S_SKIP = 3'b111
   } twcsp_sstate_t;
   typedef enum logic [3:0]
   {
      TWCSP_M_IDLE = 4'h0,
      TWCSP_M_START = 4'h1,
      TWCSP_M_LOW = 4'h2,
      TWCSP_M_HIGH = 4'h3,
      TWCSP_M_STOP_A = 4'h4,
      TWCSP_M_STOP_B = 4'h5,
      TWCSP_M_STOP_C = 4'h6,
      TWCSP_M_RS_A = 4'h7,
      TWCSP_M_RS_B = 4'h8
   } twcsp_mstate_t;
endpackage : twcsp_pkg

// >>> rtl/twcsp_bus_if.sv
// Two-wire bus wires with open-drain resolution between master and slave
interface twcsp_bus_if;
   logic m_scl_oe;
   logic m_sda_oe;
   logic s_sda_oe;
   logic scl;
   logic sda;
   // Open drain: any enabled driver pulls low, otherwise the pull-up wins
   assign scl = ~m_scl_oe;
   assign sda = ~(m_sda_oe | s_sda_oe);
   modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
   modport slave (output s_sda_oe, input scl, input sda);
endinterface : twcsp_bus_if

// >>> rtl/twcsp_slave.sv
// Device end: two-wire slave port reaching the configuration registers
// Operation
// - Bus idle when both lines high
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - SDA changes only while SCL low
// - Eight bits then ninth acknowledge bit
// - Any number of bytes per transfer
// - Works at regular and fast rates
// - Acknowledge holds SDA low through high
// - Master makes every clock pulse
// - Refuse with not-acknowledge during commit
// - Release SDA after master not-acknowledge
// - Write: acknowledge address and every byte
// - Read: acknowledge address, then send bytes
// - Repeated start restarts address reception
// - Hardware compares identifier and identity bits
// - Read direction switches to transmitting
// - Address: identifier, identity bits, direction
// - Programmable bits from identity register
`include "twcsp_params.svh"
module twcsp_slave
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   twcsp_bus_if.slave bus,
   input wire logic [2:0] i_bus_identity_bits,
   input wire logic i_commit_to_nonvolatile,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_take,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_start,
   output logic o_stop,
   output logic o_busy
);
   import twcsp_pkg::*;

   // ----------------------------------------
   // Pin synchronisers and condition detect
   // ----------------------------------------
   logic scl_meta;
   logic scl_sync;
   logic scl_prev;
   logic sda_meta;
   logic sda_sync;
   logic sda_prev;
   // Three flops per pin; only the second and later stages feed logic
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_meta <= bus.scl;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   // Edge strobes; sampling at 100 MHz covers both bus rates
   wire scl_rise = scl_sync & ~scl_prev;
   wire scl_fall = ~scl_sync & scl_prev;
   // SDA moving under a steady high clock is a condition, not data
   wire start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
   wire stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;

   // ----------------------------------------
   // Byte engine
   // ----------------------------------------
   twcsp_sstate_t state;
   twcsp_sstate_t next_state;
   logic [7:0] shreg;
   logic [3:0] bit_cnt;
   logic reading;
   logic sda_oe;
   logic [7:0] tx_shift;

   // Address layout MSB first: identifier, identity bits, direction
   wire addr_match = (shreg[7:1] == {`TWCSP_DEV_ID, i_bus_identity_bits});
   wire byte_done = scl_fall & (bit_cnt == `TWCSP_BYTE_BITS);
   // Refuse everything while the commit runs
   wire ack_addr = addr_match & ~i_commit_to_nonvolatile;
   wire ack_data = ~i_commit_to_nonvolatile;

   // Next-state selection, advancing on SCL falling edges; start and stop conditions override at once
   always_comb
   begin
      next_state = state;
      case (state)
         TWCSP_S_ADDR:
            if (byte_done)
               next_state = ack_addr ? TWCSP_S_AACK : TWCSP_S_SKIP;
         TWCSP_S_AACK:
            if (scl_fall)
               next_state = reading ? TWCSP_S_TX : TWCSP_S_RX;
         TWCSP_S_RX:
            if (byte_done)
               next_state = ack_data ? TWCSP_S_RACK : TWCSP_S_SKIP;
         TWCSP_S_RACK:
            if (scl_fall)
               next_state = TWCSP_S_RX;
         TWCSP_S_TX:
            if (byte_done)
               next_state = TWCSP_S_TACK;
         TWCSP_S_TACK:
            if (scl_fall)
               next_state = sda_sync ? TWCSP_S_SKIP : TWCSP_S_TX;
         default:
            next_state = state;
      endcase
      if (start_seen)
         next_state = TWCSP_S_ADDR;
      else if (stop_seen)
         next_state = TWCSP_S_IDLE;
   end

   // State, bit counter and shift register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state <= TWCSP_S_IDLE;
         bit_cnt <= 4'h0;
         shreg <= `TWCSP_RST_BYTE;
         reading <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (start_seen || (scl_fall && next_state != state))
            bit_cnt <= 4'h0;
         else if (scl_rise && bit_cnt != `TWCSP_BYTE_BITS)
            bit_cnt <= bit_cnt + 4'h1;
         if (scl_rise && (state == TWCSP_S_ADDR || state == TWCSP_S_RX))
            shreg <= {shreg[6:0], sda_sync};
         if (state == TWCSP_S_ADDR && byte_done)
            reading <= shreg[`TWCSP_RW_BIT];
      end
   end

   // Transmit shifter: loaded as a read byte begins, shifted on SCL fall
   wire tx_load = scl_fall & (next_state == TWCSP_S_TX) & (state != TWCSP_S_TX);
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         tx_shift <= `TWCSP_RST_BYTE;
      else if (tx_load)
         tx_shift <= i_tx_data;
      else if (scl_fall && state == TWCSP_S_TX)
         tx_shift <= {tx_shift[6:0], 1'b0};
   end

   // ----------------------------------------
   // SDA drive, updated on SCL fall and released on start or stop
   // ----------------------------------------
   // Changing the drive only after SCL falls keeps the line steady while high
   wire drive_ack = (next_state == TWCSP_S_AACK) | (next_state == TWCSP_S_RACK);
   wire drive_tx = (next_state == TWCSP_S_TX) & ~(tx_load ? i_tx_data[7] : tx_shift[6]);
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         sda_oe <= 1'b0;
      else if (start_seen || stop_seen)
         sda_oe <= 1'b0;
      else if (scl_fall)
         sda_oe <= drive_ack | drive_tx;
   end
   assign bus.s_sda_oe = sda_oe;

   // ----------------------------------------
   // User-side strobes
   // ----------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_rx_data <= `TWCSP_RST_BYTE;
         o_rx_valid <= 1'b0;
         o_tx_take <= 1'b0;
         o_start <= 1'b0;
         o_stop <= 1'b0;
      end
      else
      begin
         o_rx_valid <= (state == TWCSP_S_RX) & byte_done & ack_data;
         if (state == TWCSP_S_RX && byte_done)
            o_rx_data <= shreg;
         o_tx_take <= tx_load;
         o_start <= start_seen;
         o_stop <= stop_seen;
      end
   end
   assign o_busy = (state != TWCSP_S_IDLE);
endmodule : twcsp_slave

// >>> tb/twcsp_properties.sv
// Wire-level checks watching the bus between the master and slave ends
module twcsp_properties
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic m_scl_oe,
   input wire logic m_sda_oe,
   input wire logic s_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   // ------------------------------------------------------------
   // Bit position tracking
   // ------------------------------------------------------------
   logic prev_scl;
   logic prev_sda;
   logic data_ph;
   logic rd_dir;
   logic [3:0] bitn;
   logic [7:0] hi_len;
   // Edge and condition decode from the resolved wire levels
   wire rise = scl & ~prev_scl;
   wire start_ev = scl & prev_scl & prev_sda & ~sda;
   wire stop_ev = scl & prev_scl & ~prev_sda & sda;
   wire [3:0] next_bitn = (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
   wire nack_ev = rise & (next_bitn == 4'h9) & data_ph & rd_dir & sda;
   // Start and stop realign the count, so a repeated start restarts it
   always_ff @(posedge i_sys_clk)
   begin
      prev_scl <= i_rst | scl;
      prev_sda <= i_rst | sda;
      hi_len <= (i_rst | ~scl) ? 8'h00 : hi_len + {7'h00, hi_len != 8'hff};
      if (i_rst | start_ev | stop_ev)
      begin
         bitn <= 4'h0;
         data_ph <= 1'b0;
      end
      else if (rise)
      begin
         bitn <= next_bitn;
         data_ph <= data_ph | (bitn == 4'h9);
      end
   end
   // Direction bit is the eighth bit of the address byte
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         rd_dir <= 1'b0;
      else if (rise & (next_bitn == 4'h8) & ~data_ph)
         rd_dir <= sda;
   end
   sequence idle_s;
      scl && sda;
   endsequence
   sequence held_start_s;
      scl && !sda;
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   slave_low_timing_a: assert property ($rose(s_sda_oe) |-> !scl)
      else $error("slave pulled data low while clock high");
   ack_held_a: assert property (scl && $past(scl) && $past(s_sda_oe) |-> s_sda_oe)
      else $error("slave let data go during clock high");
   start_hold_a: assert property (start_ev |=> held_start_s [*8])
      else $error("start condition not held");
   stop_idle_a: assert property (stop_ev |=> idle_s [*8])
      else $error("bus not idle after stop");
   scl_high_len_a: assert property ($fell(scl) |-> hi_len >= 8'd100)
      else $error("clock high phase too short");
   addr_quiet_a: assert property (scl && !rise && !data_ph && bitn != 4'h0 && bitn != 4'h9
      |-> !s_sda_oe)
      else $error("slave drove data during address bits");
   write_quiet_a: assert property (scl && !rise && data_ph && !rd_dir && bitn != 4'h9
      |-> !s_sda_oe)
      else $error("slave drove data during written bits");
   rd_ack_free_a: assert property (scl && !rise && data_ph && rd_dir && bitn == 4'h9
      |-> !s_sda_oe)
      else $error("slave drove the master acknowledge slot");
   nack_release_a: assert property (nack_ev |=> !s_sda_oe [*8])
      else $error("slave kept data after not-acknowledge");
endmodule : twcsp_properties

// >>> tb/two_wire_config_slave_port_bench.sv
// Self-checking bench joining the master and slave ends across one bus
module two_wire_config_slave_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic fast = 1'b1;
   logic commit = 1'b0;
   logic [2:0] bid = 3'b101;
   logic [7:0] tx_data = 8'h96;
   logic c_valid = 1'b0;
   logic [3:0] c_flag = 4'h0;
   logic [7:0] c_data = 8'h00;
   logic tx_take, rx_valid, s_start, s_stop, s_busy, c_ready, c_done, ack_seen;
   logic [7:0] rx_data, rd_data;
   logic [7:0] rx_last = 8'h00;
   int st_cnt = 0;
   int sp_cnt = 0;
   int cycles = 0;
   int err_total = 0;
   int total_checks = 0;
   always #5 sys_clk = ~sys_clk;
   twcsp_bus_if bus();
   twcsp_slave u_twcsp_slave
   (
      .i_sys_clk(sys_clk), .i_rst(rst), .bus(bus), .i_bus_identity_bits(bid),
      .i_commit_to_nonvolatile(commit), .i_tx_data(tx_data), .o_tx_take(tx_take),
      .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_start(s_start), .o_stop(s_stop),
      .o_busy(s_busy)
   );
   // Command flags are packed as start, stop, read, acknowledge
   twcsp_master u_twcsp_master
   (
      .i_sys_clk(sys_clk), .i_rst(rst), .bus(bus), .i_fast(fast), .i_cmd_valid(c_valid),
      .i_cmd_start(c_flag[3]), .i_cmd_stop(c_flag[2]), .i_cmd_read(c_flag[1]),
      .i_cmd_ack(c_flag[0]), .i_cmd_data(c_data), .o_cmd_ready(c_ready), .o_done(c_done),
      .o_rd_data(rd_data), .o_ack_seen(ack_seen)
   );
   twcsp_properties u_twcsp_properties
   (
      .i_sys_clk(sys_clk), .i_rst(rst), .m_scl_oe(bus.m_scl_oe), .m_sda_oe(bus.m_sda_oe),
      .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda)
   );
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic close_out();
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic chk_ack(input logic e);
      check("ack", {7'h00, e}, {7'h00, ack_seen});
   endtask : chk_ack
   // Request held from just after an edge until the edge that takes it
   task automatic cmd(input logic [3:0] f, input logic [7:0] d);
      @(posedge sys_clk);
      c_flag <= f;
      c_data <= d;
      c_valid <= 1'b1;
      @(negedge sys_clk);
      while (c_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      c_valid <= 1'b0;
      while (c_done !== 1'b1) @(negedge sys_clk);
   endtask : cmd
   // Side monitor; read data flips per byte so each read byte differs
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1) rx_last <= rx_data;
      if (tx_take === 1'b1) tx_data <= ~tx_data;
      if (s_start === 1'b1) st_cnt <= st_cnt + 1;
      if (s_stop === 1'b1) sp_cnt <= sp_cnt + 1;
      if (cycles == 95000)
      begin
         err_total++;
         close_out();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      cmd(4'b1000, 8'haa);
      chk_ack(1'b1);
      check("busy", 8'h01, {7'h00, s_busy});
      cmd(4'b0000, 8'h5c);
      chk_ack(1'b1);
      check("rx_data", 8'h5c, rx_last);
      cmd(4'b0100, 8'ha3);
      check("rx_data", 8'ha3, rx_last);
      // Every identity value, then a wrong identifier and wrong identity bits
      for (int k = 0; k < 8; k++)
      begin
         bid <= 3'(k);
         cmd(4'b1100, {4'ha, 3'(k), 1'b0});
         chk_ack(1'b1);
      end
      cmd(4'b1100, 8'h5e);
      chk_ack(1'b0);
      cmd(4'b1100, 8'hac);
      chk_ack(1'b0);
      // The stop follows the last done by three quarters; let it land first
      repeat (300) @(posedge sys_clk);
      check("busy", 8'h00, {7'h00, s_busy});
      check("starts", 8'd11, 8'(st_cnt));
      check("stops", 8'd11, 8'(sp_cnt));
      commit <= 1'b1;
      cmd(4'b1100, 8'hae);
      chk_ack(1'b0);
      commit <= 1'b0;
      cmd(4'b1100, 8'hae);
      chk_ack(1'b1);
      cmd(4'b1000, 8'haf);
      chk_ack(1'b1);
      cmd(4'b0011, 8'h00);
      check("rd_data", 8'h96, rd_data);
      cmd(4'b0110, 8'h00);
      check("rd_data", 8'h69, rd_data);
      tx_data <= 8'h5a;
      cmd(4'b1000, 8'hae);
      cmd(4'b1000, 8'haf);
      chk_ack(1'b1);
      cmd(4'b0110, 8'h00);
      check("rd_data", 8'h5a, rd_data);
      fast <= 1'b0;
      cmd(4'b1000, 8'hae);
      chk_ack(1'b1);
      cmd(4'b0100, 8'h0f);
      check("rx_data", 8'h0f, rx_last);
      close_out();
   end
endmodule : two_wire_config_slave_port_bench
